// >>> include/srsb_defs.svh
// Operation
// - Reset pin output except during scan test
// - Four reset symbols with self reset drive low
// - Output select bit sets event pin direction
// - Each input edge while idle, and each group of edges within one burst, sends event symbols
// - Forwarding settings gate sending; trigger settings choose command field
// - One symbol per enabled trigger command
// - Received enabled command toggles output pin
// - Device reset clears all sideband logic
`ifndef SRSB_DEFS_SVH
`define SRSB_DEFS_SVH
`define SRSB_CMD_W        8
`define SRSB_CMD_IDX_W    3
`define SRSB_RST_SYM_NEED 3'h4
`define SRSB_CNT_W        3
`endif

// >>> include/srsb_pkg.sv
package srsb_pkg;
  typedef logic [7:0] srsb_cmd_t;
  typedef logic [2:0] srsb_idx_t;
  typedef enum logic [1:0] {SRSB_IDLE, SRSB_SEND} srsb_state_e;
endpackage

// >>> include/srsb_sym_if.sv
`timescale 1ns/1ns
`default_nettype none
// Event symbol request path between edge detector and sequencer
interface srsb_sym_if;
  logic                edge_req;
  logic                busy;
  modport src (output edge_req, input busy);
  modport seq (input edge_req, output busy);
endinterface
`default_nettype wire

// >>> rtl/srsb_tx_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "srsb_defs.svh"
module srsb_tx_seq (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic          cen,
  // Command selection
  input  wire logic [7:0]    trig_mask,
  // Request side
  srsb_sym_if.seq            req,
  // Symbol output
  output logic               sym_valid,
  output srsb_pkg::srsb_idx_t sym_cmd,
  input  wire logic          sym_ready
);
  srsb_pkg::srsb_state_e state;
  logic [7:0]            pend;
  logic [7:0]            pend_pick;

  // Lowest pending command first
  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = i[2:0];
      end
    end
  endfunction

  assign pend_pick = pend & ~(8'h01 << first_set(pend));
  assign req.busy  = (state == srsb_pkg::SRSB_SEND);

  // Walk the enabled commands, one symbol each
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state     <= srsb_pkg::SRSB_IDLE;
      pend      <= 8'h00;
      sym_valid <= 1'b0;
      sym_cmd   <= 3'h0;
    end else if (cen) begin
      case (state)
        srsb_pkg::SRSB_IDLE: begin
          if (req.edge_req && (trig_mask != 8'h00)) begin
            pend      <= trig_mask;
            sym_valid <= 1'b1;
            sym_cmd   <= first_set(trig_mask);
            state     <= srsb_pkg::SRSB_SEND;
          end
        end
        srsb_pkg::SRSB_SEND: begin
          if (sym_valid && sym_ready) begin
            pend <= pend_pick;
            if (pend_pick == 8'h00) begin
              sym_valid <= 1'b0;
              state     <= srsb_pkg::SRSB_IDLE;
            end else begin
              sym_cmd <= first_set(pend_pick);
            end
          end
        end
        default: begin
          state <= srsb_pkg::SRSB_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/srsb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "srsb_defs.svh"
module srsb_top (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       cen,
  // Configuration
  input  wire logic       scan_mode,
  input  wire logic       self_reset_enable,
  input  wire logic       event_pin_output_select,
  input  wire logic       event_forward_a,
  input  wire logic       multicast_symbol_select,
  input  wire logic [7:0] event_trigger_enable_reg,
  input  wire logic [7:0] event_capture_enable_reg,
  // Received control symbols
  input  wire logic       rx_reset_sym,
  input  wire logic       rx_other_sym,
  input  wire logic       rx_event_sym,
  input  wire logic [2:0] rx_event_cmd,
  // Transmit event symbols
  output logic            tx_event_valid,
  output logic [2:0]      tx_event_cmd,
  input  wire logic       tx_event_ready,
  // Link reset pin
  output logic            link_reset_out_n,
  output logic            link_reset_oe,
  input  wire logic       link_reset_in,
  output logic            link_reset_seen_n,
  // Event pin
  input  wire logic       event_pin_in,
  output logic            event_pin_out,
  output logic            event_pin_oe
);
  srsb_sym_if sif ();
  logic [2:0] rst_cnt;
  logic       sync_a;
  logic       sync_b;
  logic       sync_prev;
  logic       edge_pend;
  logic       fwd_on;

  // Reset symbol run counter; other symbols or a cleared enable break the run,
  // so a run that began before self reset was enabled cannot count
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_cnt          <= 3'h0;
      link_reset_out_n <= 1'b1;
    end else if (cen) begin
      if (!self_reset_enable || rx_other_sym || rx_event_sym) begin
        rst_cnt <= 3'h0;
      end else if (rx_reset_sym && rst_cnt != `SRSB_RST_SYM_NEED) begin
        rst_cnt <= rst_cnt + 3'h1;
      end
      if (rx_reset_sym && self_reset_enable && rst_cnt >= `SRSB_RST_SYM_NEED - 3'h1) begin
        link_reset_out_n <= 1'b0;
      end
    end
  end

  // Link reset pin direction and sampled input
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      link_reset_oe     <= 1'b1;
      link_reset_seen_n <= 1'b1;
    end else if (cen) begin
      link_reset_oe     <= !scan_mode;
      link_reset_seen_n <= scan_mode ? link_reset_in : 1'b1;
    end
  end

  // Two-flop synchroniser then edge detect
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_prev <= 1'b0;
      edge_pend <= 1'b0;
    end else if (cen) begin
      sync_a    <= event_pin_in;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      if (!event_pin_output_select && (sync_b ^ sync_prev)) begin
        edge_pend <= 1'b1;
      end else if (!sif.busy) begin
        edge_pend <= 1'b0;
      end
    end
  end

  // Forwarding must be subscribed and multicast selected
  assign fwd_on       = event_forward_a && multicast_symbol_select;
  assign sif.edge_req = edge_pend && fwd_on;

  srsb_tx_seq u_seq (
    .mclk      (mclk),
    .nrst      (nrst),
    .cen       (cen),
    .trig_mask (event_trigger_enable_reg),
    .req       (sif.seq),
    .sym_valid (tx_event_valid),
    .sym_cmd   (tx_event_cmd),
    .sym_ready (tx_event_ready)
  );

  // Event pin direction and toggle on captured commands
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      event_pin_oe  <= 1'b0;
      event_pin_out <= 1'b0;
    end else if (cen) begin
      event_pin_oe <= event_pin_output_select;
      if (event_pin_output_select && rx_event_sym &&
          event_capture_enable_reg[rx_event_cmd]) begin
        event_pin_out <= !event_pin_out;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/srsb_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the reset pin, the event pin and the symbol handshake
module srsb_chk (
  // Clock, reset and configuration
  input wire logic       mclk, nrst, cen, scan_mode, self_reset_enable,
  input wire logic       event_pin_output_select,
  input wire logic [7:0] event_trigger_enable_reg, event_capture_enable_reg,
  // Symbols and pins
  input wire logic       rx_reset_sym, rx_other_sym, rx_event_sym, tx_event_valid,
  input wire logic       tx_event_ready, link_reset_out_n, link_reset_oe, event_pin_out,
  input wire logic [2:0] rx_event_cmd, tx_event_cmd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  rst_fire_a: assert property (
    (cen && self_reset_enable && rx_reset_sym && !rx_other_sym && !rx_event_sym)[*4]
    |=> !link_reset_out_n) else $error("reset run missed");
  rst_hold_a: assert property (
    !link_reset_out_n |=> !link_reset_out_n) else $error("reset pin released");
  rst_cause_a: assert property (
    $fell(link_reset_out_n) |-> $past(self_reset_enable && rx_reset_sym))
    else $error("reset pin fell without cause");
  pin_dir_a: assert property (
    $past(nrst) && $past(cen) |-> link_reset_oe == !$past(scan_mode))
    else $error("reset pin direction");
  pin_tog_a: assert property (
    cen && event_pin_output_select && rx_event_sym && event_capture_enable_reg[rx_event_cmd]
    |=> event_pin_out != $past(event_pin_out)) else $error("event pin not toggled");
  pin_keep_a: assert property (
    !(rx_event_sym && event_capture_enable_reg[rx_event_cmd]) |=> $stable(event_pin_out))
    else $error("event pin moved");
  tx_hold_a: assert property (
    tx_event_valid && !tx_event_ready |=> tx_event_valid && $stable(tx_event_cmd))
    else $error("symbol dropped");
  tx_mask_a: assert property (
    tx_event_valid |-> event_trigger_enable_reg[tx_event_cmd]) else $error("command off");
endmodule
`default_nettype wire

// >>> bench/srsb_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far link end: takes event symbols after a chosen stall
module srsb_link_model (
  input wire logic       mclk,
  input wire logic       tx_event_valid,
  input wire logic [2:0] tx_event_cmd,
  output logic           tx_event_ready
);
  logic [2:0] got[$];
  int         slow = 0;
  int         w = 0;
  initial tx_event_ready = 0;
  // Log accepted commands, raise ready after the stall
  always @(posedge mclk) begin
    if (tx_event_ready) begin
      got.push_back(tx_event_cmd);
      w = 0;
    end else if (tx_event_valid) w++;
    #1 tx_event_ready = !tx_event_ready && tx_event_valid && w > slow;
  end
endmodule
`default_nettype wire

// >>> bench/srsb_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module srsb_top_bench;
  logic mclk, nrst, cen, scan_mode, self_reset_enable, event_pin_output_select;
  logic event_forward_a, multicast_symbol_select, rx_reset_sym, rx_other_sym, rx_event_sym;
  logic link_reset_in, event_pin_in, tx_event_valid, tx_event_ready, link_reset_out_n;
  logic link_reset_oe, link_reset_seen_n, event_pin_out, event_pin_oe;
  logic [2:0] rx_event_cmd, tx_event_cmd;
  logic [7:0] event_trigger_enable_reg, event_capture_enable_reg;
  int err_count = 0, n_tests = 0;
  srsb_top u_srsb_top (.*);
  srsb_link_model u_srsb_link_model (.mclk, .tx_event_valid, .tx_event_cmd, .tx_event_ready);
  // Received symbol: reset, other, event, command; one cycle
  task s(input logic [5:0] v);
    {rx_reset_sym, rx_other_sym, rx_event_sym, rx_event_cmd} = v;
    @(posedge mclk) #1;
  endtask
  task ck(input logic [15:0] a, b);
    n_tests++;
    if (a !== b) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, a, b);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait for n accepted symbols
  task wt(input int n);
    for (int i = 0; i < 300 && u_srsb_link_model.got.size() < n; i++) @(posedge mclk) #1;
    if (u_srsb_link_model.got.size() < n) begin
      err_count++;
      final_report;
    end
  endtask
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    {nrst, cen, scan_mode, self_reset_enable, event_pin_output_select} = 5'h08;
    {event_forward_a, multicast_symbol_select, link_reset_in, event_pin_in} = 4'h0;
    {event_trigger_enable_reg, event_capture_enable_reg} = 16'h2910;
    s(6'h00);
    s(6'h00);
    nrst = 1;
    ck({link_reset_out_n, event_pin_out, tx_event_valid, link_reset_oe}, 16'h9);
    repeat (4) s(6'h20);
    s(6'h00);
    ck(link_reset_out_n, 1);
    self_reset_enable = 1;
    repeat (3) s(6'h20);
    s(6'h10);
    repeat (3) s(6'h20);
    s(6'h00);
    ck(link_reset_out_n, 1);
    s(6'h20);
    s(6'h00);
    ck(link_reset_out_n, 0);
    nrst = 0;
    s(6'h00);
    nrst = 1;
    ck(link_reset_out_n, 1);
    scan_mode = 1;
    repeat (2) s(6'h00);
    ck({link_reset_oe, link_reset_seen_n}, 0);
    scan_mode = 0;
    repeat (2) s(6'h00);
    ck(link_reset_oe, 1);
    {event_forward_a, multicast_symbol_select} = 2'h3;
    u_srsb_link_model.slow = 2;
    event_pin_in = 1;
    wt(3);
    ck({u_srsb_link_model.got[0], u_srsb_link_model.got[1], u_srsb_link_model.got[2]}, 16'h1d);
    ck(event_pin_oe, 0);
    event_pin_in = 0;
    wt(6);
    ck({u_srsb_link_model.got[3], u_srsb_link_model.got[4], u_srsb_link_model.got[5]}, 16'h1d);
    event_forward_a = 0;
    event_pin_in = 1;
    repeat (20) s(6'h00);
    ck(u_srsb_link_model.got.size(), 6);
    event_pin_output_select = 1;
    repeat (2) s(6'h00);
    ck(event_pin_oe, 1);
    s(6'h0c);
    s(6'h0a);
    s(6'h00);
    ck(event_pin_out, 1);
    cen = 0;
    s(6'h0c);
    cen = 1;
    s(6'h00);
    ck(event_pin_out, 1);
    final_report;
  end
endmodule
bind srsb_top srsb_chk u_srsb_chk (.*);
`default_nettype wire
